// >>> hw/ccf_pkg.sv
// How it works
// - eight-bit flags, bits 6 and 5 read one
// - bit 7 marks two's complement overflow
// - signed branches include the overflow flag
// - bit 4 catches carry from bit 3
// - decimal adjust corrects using half and carry
// - mask bit 3 set blocks maskable interrupts
// - interrupt entry sets mask after stacking registers
// - no interrupt at boundary after an op clears the mask (a bus write clear allows it at once)
// - bit 2 copies result bit 7, or bit 15 on a 16-bit load
// - loads and stores update negative from msb
// - bit 1 marks an all-zero result
// - loads and stores update zero flag too
// - bit 0 holds carry out or borrow
// - bit test, shifts, rotates also set carry
package ccf_pkg;

	// flag bit positions
	localparam int CCF_BIT_V = 7;
	localparam int CCF_BIT_H = 4;
	localparam int CCF_BIT_I = 3;
	localparam int CCF_BIT_N = 2;
	localparam int CCF_BIT_Z = 1;
	localparam int CCF_BIT_C = 0;

	// bits that always read as one, and the reset image (mask set)
	localparam logic [7:0] CCF_FIXED_ONES = 8'h60;
	localparam logic [7:0] CCF_FLAGS_RST  = 8'h68;

	// register byte offsets on the bus
	localparam logic [7:0] CCF_OFS_FLAGS  = 8'h00;
	localparam logic [7:0] CCF_OFS_STATUS = 8'h04;
	localparam logic [7:0] CCF_OFS_RESULT = 8'h08;

	// status register field positions
	localparam int CCF_ST_SHADOW = 0;
	localparam int CCF_ST_ALLOW  = 1;
	localparam int CCF_ST_TAKEN  = 2;

	// operations reported by the decoder
	typedef enum logic [4:0] {
		CCF_OP_NONE = 5'b00000,
		CCF_OP_ADD  = 5'b00001,
		CCF_OP_ADC  = 5'b00010,
		CCF_OP_SUB  = 5'b00011,
		CCF_OP_SBC  = 5'b00100,
		CCF_OP_AND  = 5'b00101,
		CCF_OP_OR   = 5'b00110,
		CCF_OP_XOR  = 5'b00111,
		CCF_OP_SHL  = 5'b01000,
		CCF_OP_SHR  = 5'b01001,
		CCF_OP_ROL  = 5'b01010,
		CCF_OP_ROR  = 5'b01011,
		CCF_OP_DADJ = 5'b01100,
		CCF_OP_LD8  = 5'b01101,
		CCF_OP_LD16 = 5'b01110,
		CCF_OP_A2F  = 5'b01111,
		CCF_OP_UNM  = 5'b10000,
		CCF_OP_MASK = 5'b10001,
		CCF_OP_BTST = 5'b10010
	} ccf_op_e;

	// branch conditions evaluated against the flags
	typedef enum logic [2:0] {
		CCF_BR_SGT = 3'b000,
		CCF_BR_SGE = 3'b001,
		CCF_BR_SLE = 3'b010,
		CCF_BR_SLT = 3'b011,
		CCF_BR_EQ  = 3'b100,
		CCF_BR_NE  = 3'b101,
		CCF_BR_CS  = 3'b110,
		CCF_BR_CC  = 3'b111
	} ccf_br_e;

	// one retiring operation from the decoder
	typedef struct packed {
		ccf_op_e    op;
		logic [7:0] a;
		logic [7:0] b;
	} ccf_op_s;

endpackage

// >>> hw/ccf_branch.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_branch
	import ccf_pkg::*;
(
	input  wire ccf_br_e    cond_i,  // branch condition
	input  wire logic [7:0] flags_i, // current flags
	output logic            take_o   // condition true
);
	logic sgn_lt;

	// signed less-than is negative xor overflow
	// overflow in condition
	assign sgn_lt = flags_i[CCF_BIT_N] ^ flags_i[CCF_BIT_V];

	// pick the condition
	always_comb begin
		case (cond_i)
			CCF_BR_SGT: take_o = ~(flags_i[CCF_BIT_Z] | sgn_lt);
			CCF_BR_SGE: take_o = ~sgn_lt;
			CCF_BR_SLE: take_o = flags_i[CCF_BIT_Z] | sgn_lt;
			CCF_BR_SLT: take_o = sgn_lt;
			CCF_BR_EQ:  take_o = flags_i[CCF_BIT_Z];
			CCF_BR_NE:  take_o = ~flags_i[CCF_BIT_Z];
			CCF_BR_CS:  take_o = flags_i[CCF_BIT_C];
			CCF_BR_CC:  take_o = ~flags_i[CCF_BIT_C];
			default:    take_o = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// >>> hw/ccf_alu.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_alu
	import ccf_pkg::*;
(
	input  wire ccf_op_s    req_i,   // operation and operands
	input  wire logic [7:0] flags_i, // flags before the op
	output logic [15:0]     res_o,   // result value
	output logic [7:0]      flags_o, // new flag values
	output logic [7:0]      mask_o   // flags this op defines
);
	// place negative and zero into a flag image
	function automatic logic [7:0] put_nz(logic [7:0] f, logic n, logic z);
		logic [7:0] t;
		t = f;
		t[CCF_BIT_N] = n;
		t[CCF_BIT_Z] = z;
		return t;
	endfunction

	localparam logic [7:0] M_ALL = 8'h97; // V H N Z C
	localparam logic [7:0] M_VNZ = 8'h86;
	localparam logic [7:0] M_NZC = 8'h07;

	// flag and result computation per operation
	always_comb begin
		logic [8:0] s9;
		logic [4:0] s5;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] r;
		logic [7:0] corr;
		logic       cin;
		a = req_i.a;
		b = req_i.b;
		s9 = 9'h000;
		s5 = 5'h00;
		corr = 8'h00;
		r = 8'h00;
		cin = 1'b0;
		flags_o = flags_i;
		mask_o = 8'h00;
		res_o = 16'h0000;
		case (req_i.op)
			CCF_OP_ADD, CCF_OP_ADC: begin
				cin = (req_i.op == CCF_OP_ADC) ? flags_i[CCF_BIT_C] : 1'b0;
				s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
				s5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
				r = s9[7:0];
				flags_o[CCF_BIT_H] = s5[4];
				flags_o[CCF_BIT_C] = s9[8];
				flags_o[CCF_BIT_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
				flags_o = put_nz(flags_o, r[7], r == 8'h00);
				mask_o = M_ALL;
			end
			CCF_OP_SUB, CCF_OP_SBC: begin
				cin = (req_i.op == CCF_OP_SBC) ? flags_i[CCF_BIT_C] : 1'b0;
				s9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
				r = s9[7:0];
				flags_o[CCF_BIT_C] = s9[8];
				flags_o[CCF_BIT_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
				flags_o = put_nz(flags_o, r[7], r == 8'h00);
				mask_o = M_VNZ | M_NZC;
			end
			CCF_OP_AND, CCF_OP_OR, CCF_OP_XOR: begin
				r = (req_i.op == CCF_OP_AND) ? (a & b) :
				    (req_i.op == CCF_OP_OR) ? (a | b) : (a ^ b);
				flags_o[CCF_BIT_V] = 1'b0;
				flags_o = put_nz(flags_o, r[7], r == 8'h00);
				mask_o = M_VNZ;
			end
			CCF_OP_SHL, CCF_OP_SHR, CCF_OP_ROL, CCF_OP_ROR: begin
				case (req_i.op)
					CCF_OP_SHL: r = {a[6:0], 1'b0};
					CCF_OP_SHR: r = {1'b0, a[7:1]};
					CCF_OP_ROL: r = {a[6:0], flags_i[CCF_BIT_C]};
					default:    r = {flags_i[CCF_BIT_C], a[7:1]};
				endcase
				flags_o[CCF_BIT_C] = (req_i.op == CCF_OP_SHL || req_i.op == CCF_OP_ROL) ?
				                     a[7] : a[0];
				flags_o = put_nz(flags_o, r[7], r == 8'h00);
				// overflow after a shift is negative xor carry
				flags_o[CCF_BIT_V] = r[7] ^ flags_o[CCF_BIT_C];
				mask_o = M_VNZ | M_NZC;
			end
			CCF_OP_DADJ: begin
				corr[3:0] = (flags_i[CCF_BIT_H] || a[3:0] > 4'h9) ? 4'h6 : 4'h0;
				corr[7:4] = (flags_i[CCF_BIT_C] || a > 8'h99) ? 4'h6 : 4'h0;
				r = a + corr;
				flags_o[CCF_BIT_C] = flags_i[CCF_BIT_C] | (corr[7:4] != 4'h0);
				flags_o = put_nz(flags_o, r[7], r == 8'h00);
				mask_o = M_NZC;
			end
			CCF_OP_LD8: begin
				r = a;
				flags_o[CCF_BIT_V] = 1'b0;
				flags_o = put_nz(flags_o, a[7], a == 8'h00);
				mask_o = M_VNZ;
			end
			CCF_OP_LD16: begin
				flags_o[CCF_BIT_V] = 1'b0;
				flags_o = put_nz(flags_o, a[7], {a, b} == 16'h0000);
				mask_o = M_VNZ;
			end
			CCF_OP_BTST: begin
				flags_o[CCF_BIT_C] = a[b[2:0]];
				mask_o = 8'h01;
			end
			CCF_OP_A2F: begin
				flags_o = a | CCF_FIXED_ONES;
				mask_o = 8'hFF;
			end
			CCF_OP_UNM: begin
				flags_o[CCF_BIT_I] = 1'b0;
				mask_o = 8'h08;
			end
			CCF_OP_MASK: begin
				flags_o[CCF_BIT_I] = 1'b1;
				mask_o = 8'h08;
			end
			default: begin
				mask_o = 8'h00;
			end
		endcase
		res_o = (req_i.op == CCF_OP_LD16) ? {a, b} : {8'h00, r};
	end
endmodule
`default_nettype wire

// >>> hw/ccf_flags.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_flags
	import ccf_pkg::*;
(
	input  wire logic        clk_i,          // cpu clock, 20 MHz
	input  wire logic        rst_i,          // synchronous reset, high
	// decoder side
	input  wire logic        op_valid_i,     // one-cycle: op retires
	input  wire ccf_op_s     op_i,           // op code and operands
	input  wire logic        br_valid_i,     // one-cycle: evaluate branch
	input  wire ccf_br_e     br_cond_i,      // branch condition
	input  wire logic        boundary_i,     // one-cycle: instruction boundary
	input  wire logic        irq_stacked_i,  // one-cycle: registers pushed
	output logic [7:0]       flags_o,        // flags register image
	output logic [15:0]      result_o,       // last op result
	output logic             br_taken_o,     // last branch outcome
	output logic             br_done_o,      // one-cycle: outcome valid
	output logic             irq_allow_o,    // maskable irq may be taken
	// wishbone slave
	input  wire logic        cyc_i,          // bus cycle
	input  wire logic        stb_i,          // strobe
	input  wire logic        we_i,           // write enable
	input  wire logic [7:0]  adr_i,          // byte address
	input  wire logic [3:0]  sel_i,          // byte lanes
	input  wire logic [31:0] dat_i,          // write data
	output logic [31:0]      dat_o,          // read data
	output logic             ack_o           // cycle acknowledge
);
	// all state of the block
	typedef struct packed {
		logic [7:0]  flags;
		logic        shadow;
		logic        allow;
		logic [15:0] result;
		logic        taken;
		logic        done;
		logic        ack;
		logic [31:0] rdata;
	} ccf_state_s;

	ccf_state_s  st;
	ccf_state_s  next_st;
	logic [15:0] alu_res;
	logic [7:0]  alu_flags;
	logic [7:0]  alu_mask;
	logic        br_take;
	logic        bus_req;
	logic [7:0]  upd;
	logic        unmask_now;

	// flag arithmetic for the retiring operation
	ccf_alu u_alu (
		.req_i   (op_i),
		.flags_i (st.flags),
		.res_o   (alu_res),
		.flags_o (alu_flags),
		.mask_o  (alu_mask)
	);

	// branch condition against the current flags
	ccf_branch u_branch (
		.cond_i  (br_cond_i),
		.flags_i (st.flags),
		.take_o  (br_take)
	);

	// new request only while no ack is out, so each cycle is answered once
	assign bus_req = cyc_i & stb_i & ~st.ack;

	assign upd = (st.flags & ~alu_mask) | (alu_flags & alu_mask);

	// an op that takes the mask from set to clear
	assign unmask_now = op_valid_i & st.flags[CCF_BIT_I] & (alu_mask[CCF_BIT_I])
	                    & ~alu_flags[CCF_BIT_I];

	// next-state logic
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.ack = 1'b0;

		// software write to the flags; an op retiring the same cycle wins
		if (bus_req && we_i && adr_i == CCF_OFS_FLAGS && sel_i[0]) begin
			next_st.flags = dat_i[7:0];
		end
		if (op_valid_i) begin
			next_st.flags = upd;
			next_st.result = alu_res;
		end

		if (irq_stacked_i) begin
			next_st.flags[CCF_BIT_I] = 1'b1;
		end

		next_st.flags = next_st.flags | CCF_FIXED_ONES;

		if (unmask_now) begin
			next_st.shadow = 1'b1;
		end else if (boundary_i) begin
			next_st.shadow = 1'b0;
		end

		next_st.allow = ~next_st.flags[CCF_BIT_I] & ~next_st.shadow;

		if (br_valid_i) begin
			next_st.taken = br_take;
			next_st.done = 1'b1;
		end

		// bus answer one cycle after the request; unmapped reads as zero
		if (bus_req) begin
			next_st.ack = 1'b1;
			case (adr_i)
				CCF_OFS_FLAGS:  next_st.rdata = {24'h000000, st.flags};
				CCF_OFS_STATUS: begin
					next_st.rdata = 32'h00000000;
					next_st.rdata[CCF_ST_SHADOW] = st.shadow;
					next_st.rdata[CCF_ST_ALLOW] = st.allow;
					next_st.rdata[CCF_ST_TAKEN] = st.taken;
				end
				CCF_OFS_RESULT: next_st.rdata = {16'h0000, st.result};
				default:        next_st.rdata = 32'h00000000;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st.flags <= CCF_FLAGS_RST;
			st.shadow <= 1'b0;
			st.allow <= 1'b0;
			st.result <= 16'h0000;
			st.taken <= 1'b0;
			st.done <= 1'b0;
			st.ack <= 1'b0;
			st.rdata <= 32'h00000000;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign flags_o = st.flags;
	assign result_o = st.result;
	assign br_taken_o = st.taken;
	assign br_done_o = st.done;
	assign irq_allow_o = st.allow;
	assign dat_o = st.rdata;
	assign ack_o = st.ack;
endmodule
`default_nettype wire

// >>> bench/ccf_flags_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_flags_assertions
	import ccf_pkg::*;
(
	input wire logic        clk_i,         // clock
	input wire logic        rst_i,         // reset
	input wire logic        op_valid_i,    // op retires
	input wire ccf_op_s     op_i,          // op
	input wire logic        irq_stacked_i, // irq entry
	input wire logic [7:0]  flags_o,       // flags
	input wire logic [15:0] result_o,      // result
	input wire logic        irq_allow_o,   // irq allowed
	input wire logic        br_done_o,     // branch done
	input wire logic        br_taken_o,    // branch taken
	input wire logic        ack_o          // bus ack
);
	// operand sums give the expected carries of an add
	logic [4:0] nib_sum;
	logic [8:0] byte_sum;
	assign nib_sum = {1'b0, op_i.a[3:0]} + {1'b0, op_i.b[3:0]};
	assign byte_sum = {1'b0, op_i.a} + {1'b0, op_i.b};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_fixed_ones: assert property (flags_o[6:5] == 2'b11)
		else $error("fixed bits not one");
	a_mask_blocks: assert property (irq_allow_o |-> !flags_o[3])
		else $error("irq allowed while masked");
	a_stack_masks: assert property (irq_stacked_i |=> flags_o[3] && !irq_allow_o)
		else $error("mask not set on entry");
	a_unmask_shadow: assert property (op_valid_i && flags_o[3] &&
		op_i.op inside {CCF_OP_UNM, CCF_OP_A2F} |=> !irq_allow_o)
		else $error("irq allowed in shadow");
	a_logic_nz: assert property (op_valid_i &&
		op_i.op inside {CCF_OP_AND, CCF_OP_OR, CCF_OP_XOR} |=>
		flags_o[2] == result_o[7] && flags_o[1] == (result_o[7:0] == 8'h00))
		else $error("logic n or z wrong");
	a_load_nz: assert property (op_valid_i && op_i.op == CCF_OP_LD16 |=>
		flags_o[2] == result_o[15] && flags_o[1] == (result_o == 16'h0000))
		else $error("load n or z wrong");
	a_half_carry: assert property (op_valid_i && op_i.op == CCF_OP_ADD |=>
		flags_o[4] == $past(nib_sum[4]))
		else $error("half carry wrong");
	a_carry_out: assert property (op_valid_i && op_i.op == CCF_OP_ADD |=>
		flags_o[0] == $past(byte_sum[8]))
		else $error("carry out wrong");
	a_test_keeps: assert property (op_valid_i && op_i.op == CCF_OP_BTST && !irq_stacked_i
		|=> flags_o[7:1] == $past(flags_o[7:1]))
		else $error("bit test changed flags");
	c_branch: cover property (br_done_o && br_taken_o);
	c_stack: cover property (irq_stacked_i);
	c_bus: cover property (ack_o);
endmodule
`default_nettype wire

// >>> bench/ccf_dec_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_dec_model
	import ccf_pkg::*;
(
	input  wire logic    clk_i,      // clock
	output var  logic    op_valid_o, // op retires
	output var  ccf_op_s op_o,       // op
	output var  logic    br_valid_o, // branch request
	output var  ccf_br_e br_cond_o,  // condition
	output var  logic    bound_o,    // boundary
	output var  logic    stacked_o   // irq entry
);
	// all strobes idle at start
	initial begin
		op_valid_o = 1'b0;
		op_o = '0;
		br_valid_o = 1'b0;
		br_cond_o = CCF_BR_SGT;
		bound_o = 1'b0;
		stacked_o = 1'b0;
	end
	// operands are scrambled once the op has gone, so no stale value passes
	task automatic retire(input ccf_op_e o, input logic [7:0] a, b);
		@(posedge clk_i);
		op_valid_o <= 1'b1;
		op_o <= '{o, a, b};
		@(posedge clk_i);
		op_valid_o <= 1'b0;
		op_o <= ~op_o;
	endtask
	task automatic branch(input ccf_br_e c);
		@(posedge clk_i);
		br_valid_o <= 1'b1;
		br_cond_o <= c;
		@(posedge clk_i);
		br_valid_o <= 1'b0;
	endtask
	task automatic bound();
		@(posedge clk_i);
		bound_o <= 1'b1;
		@(posedge clk_i);
		bound_o <= 1'b0;
	endtask
	task automatic stack();
		@(posedge clk_i);
		stacked_o <= 1'b1;
		@(posedge clk_i);
		stacked_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> bench/ccf_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_flags_tb
	import ccf_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        op_valid_i, br_valid_i, boundary_i, irq_stacked_i;
	ccf_op_s     op_i;
	ccf_br_e     br_cond_i;
	logic [7:0]  flags_o, adr_i = 8'h00;
	logic [15:0] result_o;
	logic        br_taken_o, br_done_o, irq_allow_o, ack_o;
	logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	int          failures = 0, tests_run = 0, cycles = 0;
	always #25 clk_i = ~clk_i;
	ccf_flags i_dut (.clk_i, .rst_i, .op_valid_i, .op_i, .br_valid_i, .br_cond_i, .boundary_i,
		.irq_stacked_i, .flags_o, .result_o, .br_taken_o, .br_done_o, .irq_allow_o,
		.cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o);
	ccf_dec_model i_dec (.clk_i, .op_valid_o(op_valid_i), .op_o(op_i), .br_valid_o(br_valid_i),
		.br_cond_o(br_cond_i), .bound_o(boundary_i), .stacked_o(irq_stacked_i));
	task automatic stop_test();
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// request held until ack is sampled; the slave sets the pace
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask
	task automatic run(input ccf_op_e o, input logic [7:0] a, b);
		i_dec.retire(o, a, b);
		@(negedge clk_i);
	endtask
	task automatic t_regs();
		@(negedge clk_i);
		chk(flags_o, CCF_FLAGS_RST);
		wb(1'b1, CCF_OFS_FLAGS, 32'h0);
		wb(1'b0, CCF_OFS_FLAGS, 32'h0);
		chk(rd, 32'h60);
		@(negedge clk_i);
		chk(irq_allow_o, 1'b1);
		wb(1'b1, CCF_OFS_FLAGS, 32'hFF);
		// low lane disabled: this write must leave the flags alone
		wb(1'b1, CCF_OFS_FLAGS, 32'h00, 4'hE);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		@(negedge clk_i);
		chk({flags_o, 7'h0, irq_allow_o}, 16'hFF00);
	endtask
	task automatic t_arith();
		wb(1'b1, CCF_OFS_FLAGS, 32'h60);
		run(CCF_OP_ADD, 8'h7F, 8'h01);
		chk({result_o, flags_o}, 24'h0080F4);
		run(CCF_OP_ADD, 8'hFF, 8'h01);
		chk(flags_o, 8'h73);
		run(CCF_OP_SUB, 8'h80, 8'h01);
		chk(flags_o & 8'hEF, 8'hE0);
		run(CCF_OP_SUB, 8'h00, 8'h01);
		chk(flags_o & 8'hEF, 8'h65);
		run(CCF_OP_ADD, 8'h99, 8'h01);
		run(CCF_OP_DADJ, 8'h9A, 8'h00);
		chk({result_o, 7'h0, flags_o[0]}, 24'h000001);
		run(CCF_OP_ADD, 8'h19, 8'h28);
		run(CCF_OP_DADJ, 8'h41, 8'h00);
		chk(result_o, 16'h0047);
		run(CCF_OP_LD16, 8'h80, 8'h00);
		chk(flags_o & 8'h06, 8'h04);
		wb(1'b0, CCF_OFS_RESULT, 32'h0);
		chk(rd, 32'h8000);
		run(CCF_OP_LD16, 8'h00, 8'h00);
		chk(flags_o & 8'h06, 8'h02);
	endtask
	task automatic t_shift();
		ccf_op_e ops[7] = '{CCF_OP_SHL, CCF_OP_ROL, CCF_OP_ROR, CCF_OP_SHR,
			CCF_OP_XOR, CCF_OP_BTST, CCF_OP_BTST};
		logic [7:0] av[7] = '{8'h81, 8'h00, 8'h01, 8'h01, 8'h55, 8'h04, 8'h04};
		logic [7:0] bv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h02};
		logic [7:0] rv[7] = '{8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		logic cv[7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		logic [7:0] keep;
		for (int i = 0; i < 7; i++) begin
			keep = flags_o;
			run(ops[i], av[i], bv[i]);
			chk(flags_o[0], cv[i]);
			if (ops[i] == CCF_OP_BTST)
				chk(flags_o[7:1], keep[7:1]);
			else
				chk(result_o, {8'h00, rv[i]});
		end
	endtask
	// shadow ends one boundary later; one spare cycle for the registered flag
	task automatic t_irq();
		wb(1'b1, CCF_OFS_FLAGS, 32'h68);
		run(CCF_OP_UNM, 8'h00, 8'h00);
		chk({flags_o[3], irq_allow_o}, 2'b00);
		// status shows the shadow set and the irq still held off
		wb(1'b0, CCF_OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		i_dec.bound();
		@(negedge clk_i);
		@(negedge clk_i);
		chk(irq_allow_o, 1'b1);
		run(CCF_OP_A2F, 8'h08, 8'h00);
		chk(irq_allow_o, 1'b0);
		run(CCF_OP_A2F, 8'h00, 8'h00);
		chk(irq_allow_o, 1'b0);
		i_dec.bound();
		@(negedge clk_i);
		@(negedge clk_i);
		chk(irq_allow_o, 1'b1);
		i_dec.stack();
		@(negedge clk_i);
		chk({flags_o[3], irq_allow_o}, 2'b10);
	endtask
	task automatic t_branch();
		logic [7:0] fv[4] = '{8'hE0, 8'hE4, 8'hE2, 8'h61};
		logic nv, t, e;
		for (int f = 0; f < 4; f++) begin
			wb(1'b1, CCF_OFS_FLAGS, {24'h0, fv[f]});
			nv = fv[f][2] ^ fv[f][7];
			for (int c = 0; c < 8; c++) begin
				// signed tests first, then zero and carry tests
				if (c < 4) begin
					t = c[0] ? nv : (fv[f][1] | nv);
					e = c[1] ? t : !t;
				end else begin
					t = c[1] ? fv[f][0] : fv[f][1];
					e = c[0] ? !t : t;
				end
				i_dec.branch(ccf_br_e'(c));
				@(negedge clk_i);
				chk({br_done_o, br_taken_o}, {1'b1, e});
			end
		end
	endtask
	// a hung wait ends here instead of running on
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			stop_test();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_arith();
		t_shift();
		t_irq();
		t_branch();
		stop_test();
	end
endmodule
bind ccf_flags ccf_flags_assertions i_chk (.clk_i, .rst_i, .op_valid_i, .op_i, .irq_stacked_i,
	.flags_o, .result_o, .irq_allow_o, .br_done_o, .br_taken_o, .ack_o);
`default_nettype wire
